// *** design/fis_dma_consts.vh ***
// constants for the frame transport dma bridge: offsets, fields, timing
// assumes a 32-bit register port and a 256-bit axi4 memory side
//
// Notes on behaviour
// - data-frame payloads are written from the data-frame receive base upward.
// - interrupt clear bit 31 drops the core-to-cpu interrupt.
// - interrupt clear bit 30 drops the cpu-to-core interrupt.
// - interrupt clear bit 29 clears the latched received frame type.
// - registers decode at base 0x0001_0000 (host) or 0x0002_0000 (device).
// - memory side is 256-bit axi4, link side 32-bit; fifos convert width.
// - a data-type transmit sends the data frame header first, then payload.
// - read bursts pause while the transmit fifo is more than half full.
// - link transmit pops the transmit fifo only while it is not empty.
// - receive words from the link stall while the write fifo is almost full.
// - a frame ending mid memory word is padded with dummy words.
// - a write burst is requested only once a burst of data is buffered.
// - received header type steers data to data or other-frame area.
// - every axi transfer is 16 beats of 256 bits, 512 bytes.
// - control bit 30 starts, bit 29 picks data type, bits 15:0 count.
// - control bit 31 hard-resets the controller.
// - receive count holds type in bit 31, words in 23:0; control write clears the words.
// - non-data frames go to the other-frame receive base.
`ifndef FIS_DMA_CONSTS_VH
`define FIS_DMA_CONSTS_VH

`define BASE_HOST 32'h0001_0000
`define BASE_DEVICE 32'h0002_0000
`define OFF_TX_BASE 5'h00
`define OFF_OTHER_BASE 5'h04
`define OFF_ERR_CODE 5'h04
`define OFF_CONTROL 5'h08
`define OFF_DATA_BASE 5'h0c
`define OFF_RX_COUNT 5'h0c
`define OFF_INT_CLEAR 5'h10
`define CTL_HW_RESET 31
`define CTL_START 30
`define CTL_DATA_TYPE 29
`define CLR_CORE_IRQ 31
`define CLR_CPU_IRQ 30
`define CLR_RX_TYPE 29
`define DATA_FRAME_TYPE 8'h46
`define DATA_FRAME_HDR 32'h0000_0046
`define BURST_BEATS 16
`define BURST_BYTES 32'h0000_0200
`define AXI_LEN 8'h0f
`define AXI_SIZE 3'h5
`define AXI_INCR 2'h1
`define FIFO_DEPTH 32
`define TX_ROOM_LIMIT 6'h10
`define RX_AFULL 6'h1c

`endif

// *** design/fis_transport_dma_bridge.v ***
// frame transport dma bridge: register port, transmit and receive engines
// assumes a simple single-cycle register strobe port, one clock, an axi4
// slave memory that honours 16-beat incr bursts, and a 32-bit link core
`include "fis_dma_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module fis_transport_dma_bridge #(
  parameter [31:0] BASE_ADDR = `BASE_HOST
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [31:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_wdata_i,
  output reg [31:0] reg_rdata_o,
  output reg reg_ack_o,
  output reg core_to_cpu_irq_o,
  output reg cpu_to_core_irq_o,
  input wire cpu_irq_req_i,
  input wire [31:0] link_err_code_i,
  output reg [31:0] tx_data_o,
  output reg tx_valid_o,
  output reg tx_last_o,
  input wire tx_ready_i,
  input wire [31:0] rx_data_i,
  input wire rx_valid_i,
  input wire rx_last_i,
  output reg rx_ready_o,
  output reg [31:0] m_axi_araddr,
  output wire [7:0] m_axi_arlen,
  output wire [2:0] m_axi_arsize,
  output wire [1:0] m_axi_arburst,
  output reg m_axi_arvalid,
  input wire m_axi_arready,
  input wire [255:0] m_axi_rdata,
  input wire m_axi_rvalid,
  input wire m_axi_rlast,
  output reg m_axi_rready,
  output reg [31:0] m_axi_awaddr,
  output wire [7:0] m_axi_awlen,
  output wire [2:0] m_axi_awsize,
  output wire [1:0] m_axi_awburst,
  output reg m_axi_awvalid,
  input wire m_axi_awready,
  output reg [255:0] m_axi_wdata,
  output wire [31:0] m_axi_wstrb,
  output reg m_axi_wlast,
  output reg m_axi_wvalid,
  input wire m_axi_wready,
  input wire m_axi_bvalid,
  output reg m_axi_bready
);

  localparam [1:0] W_IDLE = 2'd0;
  localparam [1:0] W_ADDR = 2'd1;
  localparam [1:0] W_DATA = 2'd2;
  localparam [1:0] W_RESP = 2'd3;

  // fixed-size bursts only, so the shape fields never change
  assign m_axi_arlen = `AXI_LEN;
  assign m_axi_awlen = `AXI_LEN;
  assign m_axi_arsize = `AXI_SIZE;
  assign m_axi_awsize = `AXI_SIZE;
  assign m_axi_arburst = `AXI_INCR;
  assign m_axi_awburst = `AXI_INCR;
  assign m_axi_wstrb = 32'hffff_ffff;

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  wire hit = (reg_addr_i[31:5] == BASE_ADDR[31:5]);
  wire wr = reg_wr_i && hit;
  wire [4:0] off = reg_addr_i[4:0];
  wire ctl_wr = wr && (off == `OFF_CONTROL);
  wire clr_wr = wr && (off == `OFF_INT_CLEAR);

  reg [31:0] tx_base_r;
  reg [31:0] other_base_r;
  reg [31:0] data_base_r;
  reg [31:0] err_code_r;
  reg rx_type_r;
  reg [23:0] rx_count_r;
  reg srst_r;
  wire rx_done;
  wire tx_done;
  reg [23:0] rx_words_r;
  reg rx_nondata_r;

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_base_r <= 32'h0;
      other_base_r <= 32'h0;
      data_base_r <= 32'h0;
      reg_rdata_o <= 32'h0;
      reg_ack_o <= 1'b0;
      srst_r <= 1'b0;
    end
    else
    begin
      reg_ack_o <= hit && (reg_wr_i || reg_rd_i);
      srst_r <= ctl_wr && reg_wdata_i[`CTL_HW_RESET];
      if (wr && off == `OFF_TX_BASE)
        tx_base_r <= reg_wdata_i;
      if (wr && off == `OFF_OTHER_BASE)
        other_base_r <= reg_wdata_i;
      if (wr && off == `OFF_DATA_BASE)
        data_base_r <= reg_wdata_i;
      reg_rdata_o <= 32'h0;
      if (reg_rd_i && hit && off == `OFF_ERR_CODE)
        reg_rdata_o <= err_code_r;
      if (reg_rd_i && hit && off == `OFF_RX_COUNT)
        reg_rdata_o <= {rx_type_r, 7'h0, rx_count_r};
    end
  end

  // ------------------------------------------------------------
  // status and interrupts; a completion beats a same-cycle clear
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      err_code_r <= 32'h0;
      rx_type_r <= 1'b0;
      rx_count_r <= 24'h0;
      core_to_cpu_irq_o <= 1'b0;
      cpu_to_core_irq_o <= 1'b0;
    end
    else
    begin
      if (ctl_wr)
        rx_count_r <= 24'h0;
      if (clr_wr && reg_wdata_i[`CLR_RX_TYPE])
        rx_type_r <= 1'b0;
      if (clr_wr && reg_wdata_i[`CLR_CORE_IRQ])
        core_to_cpu_irq_o <= 1'b0;
      if (clr_wr && reg_wdata_i[`CLR_CPU_IRQ])
        cpu_to_core_irq_o <= 1'b0;
      if (cpu_irq_req_i)
        cpu_to_core_irq_o <= 1'b1;
      if (tx_done || rx_done)
      begin
        err_code_r <= link_err_code_i;
        core_to_cpu_irq_o <= 1'b1;
      end
      if (rx_done)
      begin
        rx_count_r <= rx_words_r;
        rx_type_r <= rx_nondata_r;
      end
    end
  end

  // ------------------------------------------------------------
  // transmit: axi read into transmit_read_fifo, 32-bit out to link
  // ------------------------------------------------------------
  reg [255:0] tmem [0:`FIFO_DEPTH-1];
  reg [4:0] twr_r;
  reg [4:0] trd_r;
  reg [5:0] tcnt_r;
  reg tx_busy_r;
  reg tx_hdr_r;
  reg [15:0] tx_left_r;
  reg [15:0] rd_beats_r;
  reg ar_out_r;
  reg [2:0] tsel_r;

  wire tpush = m_axi_rvalid && m_axi_rready;
  wire tload = !tx_valid_o || tx_ready_i;
  wire tword = tload && !tx_hdr_r && tx_left_r != 16'h0 && tcnt_r != 6'h0;
  wire tpop = tword && (tsel_r == 3'd7 || tx_left_r == 16'h1);
  assign tx_done = tx_busy_r && !tx_hdr_r && tx_left_r == 16'h0 && !tx_valid_o
                   && !ar_out_r && !m_axi_arvalid && rd_beats_r == 16'h0;
  wire [16:0] beats_need = {1'b0, reg_wdata_i[15:0]} + 17'h7;

  always @(posedge clk_i)
  begin
    if (tpush)
      tmem[twr_r] <= m_axi_rdata;
  end

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      twr_r <= 5'h0;
      trd_r <= 5'h0;
      tcnt_r <= 6'h0;
      tx_busy_r <= 1'b0;
      tx_hdr_r <= 1'b0;
      tx_left_r <= 16'h0;
      rd_beats_r <= 16'h0;
      ar_out_r <= 1'b0;
      tsel_r <= 3'h0;
      tx_data_o <= 32'h0;
      tx_valid_o <= 1'b0;
      tx_last_o <= 1'b0;
      m_axi_araddr <= 32'h0;
      m_axi_arvalid <= 1'b0;
      m_axi_rready <= 1'b0;
    end
    else if (srst_r || tx_done)
    begin
      // the last burst may overshoot the count, so leftovers are dropped
      twr_r <= 5'h0;
      trd_r <= 5'h0;
      tcnt_r <= 6'h0;
      tx_busy_r <= 1'b0;
      tx_hdr_r <= 1'b0;
      tx_left_r <= 16'h0;
      rd_beats_r <= 16'h0;
      ar_out_r <= 1'b0;
      tsel_r <= 3'h0;
      tx_valid_o <= 1'b0;
      tx_last_o <= 1'b0;
      m_axi_arvalid <= 1'b0;
      m_axi_rready <= 1'b0;
    end
    else
    begin
      if (ctl_wr && reg_wdata_i[`CTL_START] && !tx_busy_r)
      begin
        tx_busy_r <= 1'b1;
        tx_hdr_r <= reg_wdata_i[`CTL_DATA_TYPE];
        tx_left_r <= reg_wdata_i[15:0];
        rd_beats_r <= {2'b00, beats_need[16:3]};
        m_axi_araddr <= tx_base_r;
      end
      if (!ar_out_r && !m_axi_arvalid && rd_beats_r != 16'h0 && tcnt_r <= `TX_ROOM_LIMIT)
        m_axi_arvalid <= 1'b1;
      if (m_axi_arvalid && m_axi_arready)
      begin
        m_axi_arvalid <= 1'b0;
        ar_out_r <= 1'b1;
        m_axi_rready <= 1'b1;
        rd_beats_r <= (rd_beats_r > 16'h10) ? rd_beats_r - 16'h10 : 16'h0;
      end
      if (tpush && m_axi_rlast)
      begin
        ar_out_r <= 1'b0;
        m_axi_rready <= 1'b0;
      end
      if (tpush)
        twr_r <= twr_r + 5'h1;
      if (tpop)
        trd_r <= trd_r + 5'h1;
      tcnt_r <= tcnt_r + {5'h0, tpush} - {5'h0, tpop};
      if (tload)
        tx_valid_o <= 1'b0;
      if (tload && tx_hdr_r)
      begin
        tx_data_o <= `DATA_FRAME_HDR;
        tx_valid_o <= 1'b1;
        tx_last_o <= (tx_left_r == 16'h0);
        tx_hdr_r <= 1'b0;
      end
      else if (tword)
      begin
        tx_data_o <= tmem[trd_r][tsel_r*32 +: 32];
        tx_valid_o <= 1'b1;
        tx_last_o <= (tx_left_r == 16'h1);
        tx_left_r <= tx_left_r - 16'h1;
        tsel_r <= tpop ? 3'h0 : tsel_r + 3'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // receive: 32-bit link words packed into receive_write_fifo
  // ------------------------------------------------------------
  reg [255:0] rmem [0:`FIFO_DEPTH-1];
  reg [4:0] rwr_r;
  reg [4:0] rrd_r;
  reg [5:0] rcnt_r;
  reg [255:0] rbuf_r;
  reg [2:0] rlane_r;
  reg rfirst_r;
  reg rpad_r;
  reg rfin_r;
  reg [3:0] rbeat_r;
  reg [31:0] rbase_r;
  reg [31:0] woff_r;
  reg [1:0] wst_r;
  reg [3:0] wbeat_r;
  wire [255:0] rword;

  wire rtake = rx_valid_i && rx_ready_o;
  wire rpush = (rtake && (rlane_r == 3'd7 || rx_last_i)) || (rpad_r && rcnt_r != 6'h20);
  wire rpop = m_axi_wvalid && m_axi_wready;
  assign rx_done = rfin_r && !rpad_r && rcnt_r == 6'h0 && wst_r == W_IDLE;

  // lanes past the last word read as zero, which is the dummy fill
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : lane
      assign rword[g*32 +: 32] = rpad_r ? 32'h0 :
                                 (rlane_r == g) ? rx_data_i :
                                 (rlane_r > g) ? rbuf_r[g*32 +: 32] : 32'h0;
    end
  endgenerate

  always @(posedge clk_i)
  begin
    if (rpush)
      rmem[rwr_r] <= rword;
  end

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rwr_r <= 5'h0;
      rrd_r <= 5'h0;
      rcnt_r <= 6'h0;
      rbuf_r <= 256'h0;
      rlane_r <= 3'h0;
      rfirst_r <= 1'b1;
      rpad_r <= 1'b0;
      rfin_r <= 1'b0;
      rbeat_r <= 4'h0;
      rbase_r <= 32'h0;
      woff_r <= 32'h0;
      wst_r <= W_IDLE;
      wbeat_r <= 4'h0;
      rx_words_r <= 24'h0;
      rx_nondata_r <= 1'b0;
      rx_ready_o <= 1'b0;
      m_axi_awaddr <= 32'h0;
      m_axi_awvalid <= 1'b0;
      m_axi_wdata <= 256'h0;
      m_axi_wvalid <= 1'b0;
      m_axi_wlast <= 1'b0;
      m_axi_bready <= 1'b0;
    end
    else if (srst_r || rx_done)
    begin
      rwr_r <= 5'h0;
      rrd_r <= 5'h0;
      rcnt_r <= 6'h0;
      rlane_r <= 3'h0;
      rfirst_r <= 1'b1;
      rpad_r <= 1'b0;
      rfin_r <= 1'b0;
      rbeat_r <= 4'h0;
      woff_r <= 32'h0;
      wst_r <= W_IDLE;
      rx_ready_o <= 1'b0;
      m_axi_awvalid <= 1'b0;
      m_axi_wvalid <= 1'b0;
      m_axi_bready <= 1'b0;
    end
    else
    begin
      // margin of four covers the one-cycle lag of the registered ready
      rx_ready_o <= (rcnt_r < `RX_AFULL) && !rpad_r && !rfin_r && !(rtake && rx_last_i);
      if (rtake)
      begin
        rx_words_r <= rfirst_r ? 24'h1 : rx_words_r + 24'h1;
        rfirst_r <= 1'b0;
        if (rfirst_r)
        begin
          rx_nondata_r <= (rx_data_i[7:0] != `DATA_FRAME_TYPE);
          rbase_r <= (rx_data_i[7:0] == `DATA_FRAME_TYPE) ? data_base_r : other_base_r;
        end
        rbuf_r[rlane_r*32 +: 32] <= rx_data_i;
        rlane_r <= rx_last_i ? 3'h0 : rlane_r + 3'h1;
        if (rx_last_i)
        begin
          rfin_r <= 1'b1;
          rpad_r <= (rbeat_r != 4'hf);
        end
      end
      if (rpush)
      begin
        rwr_r <= rwr_r + 5'h1;
        rbeat_r <= rbeat_r + 4'h1;
        if (rpad_r && rbeat_r == 4'hf)
          rpad_r <= 1'b0;
      end
      if (rpop)
        rrd_r <= rrd_r + 5'h1;
      rcnt_r <= rcnt_r + {5'h0, rpush} - {5'h0, rpop};
      case (wst_r)
        W_IDLE:
        begin
          if (rcnt_r >= `BURST_BEATS)
          begin
            m_axi_awaddr <= rbase_r + woff_r;
            m_axi_awvalid <= 1'b1;
            wst_r <= W_ADDR;
          end
        end
        W_ADDR:
        begin
          if (m_axi_awready)
          begin
            m_axi_awvalid <= 1'b0;
            m_axi_wdata <= rmem[rrd_r];
            m_axi_wvalid <= 1'b1;
            m_axi_wlast <= 1'b0;
            wbeat_r <= 4'h0;
            wst_r <= W_DATA;
          end
        end
        W_DATA:
        begin
          if (m_axi_wready)
          begin
            m_axi_wdata <= rmem[rrd_r + 5'h1];
            wbeat_r <= wbeat_r + 4'h1;
            m_axi_wlast <= (wbeat_r == 4'he);
            if (m_axi_wlast)
            begin
              m_axi_wvalid <= 1'b0;
              m_axi_bready <= 1'b1;
              wst_r <= W_RESP;
            end
          end
        end
        W_RESP:
        begin
          if (m_axi_bvalid)
          begin
            m_axi_bready <= 1'b0;
            woff_r <= woff_r + `BURST_BYTES;
            wst_r <= W_IDLE;
          end
        end
        default:
          wst_r <= W_IDLE;
      endcase
    end
  end

endmodule // fis_transport_dma_bridge

`default_nettype wire

// *** testbench/axi_mem_model.sv ***
// axi4 memory model for 16-beat bursts
// assumes one burst in flight per direction; read data is the byte address
`timescale 1ns/1ns
`default_nettype none
module axi_mem_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [255:0] rdata,
  output logic rvalid,
  output logic rlast,
  input wire logic rready,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [255:0] wdata,
  input wire logic wvalid,
  output logic wready,
  output logic bvalid,
  input wire logic bready
);
  // ----
  // read and write channels
  // ----
  logic [31:0] raddr, aw_q;
  logic [3:0] rcnt, wcnt;
  logic rd_act, wr_act;
  logic [255:0] wbeat [0:15];
  // idle data is inverted so a stale sample never matches
  always_comb
    for (int k = 0; k < 8; k++)
      rdata[k*32 +: 32] = (raddr + {rcnt, 5'h00} + k * 4) ^ {32{!rvalid}};
  assign rlast = rvalid && rcnt == 4'hf;
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      {arready, rvalid, rd_act, awready, wready, bvalid, wr_act} <= '0;
      {raddr, aw_q, rcnt, wcnt} <= '0;
    end
    else
    begin
      arready <= arvalid && !arready && !rd_act;
      if (arvalid && arready)
        {raddr, rd_act} <= {araddr, 1'b1};
      // a gap after each beat makes the memory slow
      rvalid <= (rvalid && rready) ? 1'b0 : rd_act;
      if (rvalid && rready)
        {rcnt, rd_act} <= {rcnt + 4'h1, rcnt != 4'hf};
      awready <= awvalid && !awready && !wr_act;
      if (awvalid && awready)
        {aw_q, wr_act} <= {awaddr, 1'b1};
      wready <= wr_act && !wready;
      if (bvalid && bready)
        bvalid <= 1'b0;
      if (wvalid && wready)
      begin
        wbeat[wcnt] <= wdata;
        wcnt <= wcnt + 4'h1;
        if (wcnt == 4'hf)
          {wr_act, bvalid} <= 2'b01;
      end
    end
endmodule // axi_mem_model
`default_nettype wire

// *** testbench/fis_dma_checker_assertions.sv ***
// checker for the frame transport dma bridge ports
// assumes it is bound to every bridge instance
`include "fis_dma_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module fis_dma_checker #(
  parameter [31:0] BASE_ADDR = `BASE_HOST
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_ack_o,
  input wire logic core_to_cpu_irq_o,
  input wire logic cpu_to_core_irq_o,
  input wire logic cpu_irq_req_i,
  input wire logic [31:0] tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic rx_valid_i,
  input wire logic rx_last_i,
  input wire logic rx_ready_o,
  input wire logic [7:0] m_axi_arlen,
  input wire logic [2:0] m_axi_arsize,
  input wire logic [1:0] m_axi_arburst,
  input wire logic m_axi_wvalid,
  input wire logic m_axi_wready,
  input wire logic m_axi_wlast,
  input wire logic m_axi_bvalid
);
  // ----
  // helpers
  // ----
  wire hit = reg_addr_i[31:5] == BASE_ADDR[31:5];
  wire clr_wr = reg_wr_i && hit && reg_addr_i[4:0] == `OFF_INT_CLEAR;
  wire ctl_wr = reg_wr_i && hit && reg_addr_i[4:0] == `OFF_CONTROL;
  reg busy_r;
  reg srst_r;
  reg [3:0] wbeat_r;
  // busy is only approximated, so the header check sleeps rather than misfires
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      busy_r <= 1'b0;
      srst_r <= 1'b0;
      wbeat_r <= 4'h0;
    end
    else
    begin
      busy_r <= (ctl_wr && reg_wdata_i[`CTL_START]) || (busy_r && !core_to_cpu_irq_o);
      srst_r <= (ctl_wr && reg_wdata_i[`CTL_HW_RESET]) || srst_r;
      if (m_axi_wvalid && m_axi_wready)
        wbeat_r <= wbeat_r + 4'h1;
    end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_reg_ack_timing: assert property ((reg_wr_i || reg_rd_i) && hit |=> reg_ack_o)
    else $error("no ack after a hit access");
  a_burst_shape: assert property (m_axi_arlen == `AXI_LEN && m_axi_arsize == `AXI_SIZE
    && m_axi_arburst == `AXI_INCR) else $error("read burst shape wrong");
  a_wlast_sixteenth: assert property (m_axi_wvalid |-> m_axi_wlast == (wbeat_r == 4'hf))
    else $error("wlast not on beat 16");
  a_core_irq_clear: assert property (clr_wr && reg_wdata_i[`CLR_CORE_IRQ] && !tx_valid_o
    && !m_axi_bvalid |=> !core_to_cpu_irq_o) else $error("core irq not cleared");
  a_cpu_irq_clear: assert property (clr_wr && reg_wdata_i[`CLR_CPU_IRQ] && !cpu_irq_req_i
    |=> !cpu_to_core_irq_o) else $error("cpu irq not cleared");
  a_cpu_irq_set: assert property (cpu_irq_req_i |=> cpu_to_core_irq_o)
    else $error("cpu irq not raised");
  a_core_irq_hold: assert property (core_to_cpu_irq_o && !(clr_wr && reg_wdata_i[31])
    |=> core_to_cpu_irq_o) else $error("core irq dropped alone");
  a_header_first: assert property (ctl_wr && reg_wdata_i[31:29] == 3'b011 && !busy_r
    |=> ##1 tx_valid_o && tx_data_o == `DATA_FRAME_HDR) else $error("data header not first");
  a_tx_word_held: assert property (tx_valid_o && !tx_ready_i && !ctl_wr && !srst_r
    |=> tx_valid_o && $stable(tx_data_o)) else $error("tx word changed unaccepted");
  a_rx_stop_last: assert property (rx_valid_i && rx_ready_o && rx_last_i |=> !rx_ready_o)
    else $error("rx ready after last word");
  c_tx_header: cover property (ctl_wr && reg_wdata_i[31:29] == 3'b011);
  c_rx_last: cover property (rx_valid_i && rx_ready_o && rx_last_i);
  c_irq_clear: cover property (clr_wr && core_to_cpu_irq_o);
endmodule // fis_dma_checker
bind fis_transport_dma_bridge fis_dma_checker #(.BASE_ADDR(BASE_ADDR)) chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_ack_o(reg_ack_o),
  .core_to_cpu_irq_o(core_to_cpu_irq_o), .cpu_to_core_irq_o(cpu_to_core_irq_o),
  .cpu_irq_req_i(cpu_irq_req_i), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
  .tx_ready_i(tx_ready_i), .rx_valid_i(rx_valid_i), .rx_last_i(rx_last_i),
  .rx_ready_o(rx_ready_o), .m_axi_arlen(m_axi_arlen), .m_axi_arsize(m_axi_arsize),
  .m_axi_arburst(m_axi_arburst), .m_axi_wvalid(m_axi_wvalid), .m_axi_wready(m_axi_wready),
  .m_axi_wlast(m_axi_wlast), .m_axi_bvalid(m_axi_bvalid));
`default_nettype wire

// *** testbench/tb_top.sv ***
// bench: registers, transmit, receive and irqs against the memory model
// assumes the bridge, checker and memory model are compiled first
`include "fis_dma_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ----
  // signals and instances
  // ----
  logic clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, cpu_irq_req_i = 1'b0;
  logic [31:0] reg_addr_i = '0, reg_wdata_i = '0, link_err_code_i = 32'h0000_00a5;
  logic [31:0] rx_data_i = '0, reg_rdata_o, tx_data_o, m_axi_araddr, m_axi_awaddr;
  logic rx_valid_i = 1'b0, rx_last_i = 1'b0, tx_ready_i = 1'b0, sink_on = 1'b0;
  logic reg_ack_o, core_to_cpu_irq_o, cpu_to_core_irq_o, tx_valid_o, tx_last_o, rx_ready_o;
  logic m_axi_arvalid, m_axi_arready, m_axi_rvalid, m_axi_rlast, m_axi_rready, m_axi_awvalid;
  logic m_axi_awready, m_axi_wlast, m_axi_wvalid, m_axi_wready, m_axi_bvalid, m_axi_bready;
  logic [255:0] m_axi_rdata, m_axi_wdata;
  logic [31:0] txq[$], lastq[$];
  int err_total = 0, total_checks = 0;
  localparam logic [31:0] TXB = 32'h0000_1000, DB = 32'h0000_2000, OB = 32'h0000_3000;
  fis_transport_dma_bridge dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_ack_o(reg_ack_o), .core_to_cpu_irq_o(core_to_cpu_irq_o), .cpu_irq_req_i(cpu_irq_req_i),
    .cpu_to_core_irq_o(cpu_to_core_irq_o), .link_err_code_i(link_err_code_i),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i),
    .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .rx_last_i(rx_last_i), .rx_ready_o(rx_ready_o),
    .m_axi_araddr(m_axi_araddr), .m_axi_arlen(), .m_axi_arsize(), .m_axi_arburst(),
    .m_axi_arvalid(m_axi_arvalid), .m_axi_arready(m_axi_arready), .m_axi_rdata(m_axi_rdata),
    .m_axi_rvalid(m_axi_rvalid), .m_axi_rlast(m_axi_rlast), .m_axi_rready(m_axi_rready),
    .m_axi_awaddr(m_axi_awaddr), .m_axi_awlen(), .m_axi_awsize(), .m_axi_awburst(),
    .m_axi_awvalid(m_axi_awvalid), .m_axi_awready(m_axi_awready), .m_axi_wdata(m_axi_wdata),
    .m_axi_wstrb(), .m_axi_wlast(m_axi_wlast), .m_axi_wvalid(m_axi_wvalid),
    .m_axi_wready(m_axi_wready), .m_axi_bvalid(m_axi_bvalid), .m_axi_bready(m_axi_bready));
  axi_mem_model mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .araddr(m_axi_araddr),
    .arvalid(m_axi_arvalid), .arready(m_axi_arready), .rdata(m_axi_rdata), .rvalid(m_axi_rvalid),
    .rlast(m_axi_rlast), .rready(m_axi_rready), .awaddr(m_axi_awaddr), .awvalid(m_axi_awvalid),
    .awready(m_axi_awready), .wdata(m_axi_wdata), .wvalid(m_axi_wvalid), .wready(m_axi_wready),
    .bvalid(m_axi_bvalid), .bready(m_axi_bready));
  initial
    forever #5 clk_i = ~clk_i;
  // link sink stalls every other cycle; a word counts when ready is up before the edge
  always @(negedge clk_i)
  begin
    tx_ready_i = sink_on && !tx_ready_i;
    if (tx_valid_o && tx_ready_i)
    begin
      txq.push_back(tx_data_o);
      lastq.push_back({31'h0, tx_last_o});
    end
  end
  // ----
  // shared tasks
  // ----
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic ack, output logic [31:0] q);
    @(negedge clk_i);
    {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = {a, d, w, !w};
    @(negedge clk_i);
    {reg_wdata_i, reg_wr_i, reg_rd_i} = {~d, 2'b00};
    {ack, q} = {reg_ack_o, reg_rdata_o};
  endtask
  task automatic wr(input logic [4:0] off, input logic [31:0] d);
    logic a;
    logic [31:0] q;
    acc(1'b1, `BASE_HOST | off, d, a, q);
    chk("write ack", 32'h1, {31'h0, a});
  endtask
  task automatic rd(input logic [4:0] off, input logic [31:0] exp);
    logic a;
    logic [31:0] q;
    acc(1'b0, `BASE_HOST | off, 32'h0, a, q);
    chk("read ack", 32'h1, {31'h0, a});
    chk("read data", exp, q);
  endtask
  task automatic wait_irq;
    for (int n = 0; n < 3000 && core_to_cpu_irq_o !== 1'b1; n++)
      @(negedge clk_i);
    chk("done irq", 32'h1, {31'h0, core_to_cpu_irq_o});
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_decode;
    logic a;
    logic [31:0] q;
    rd(`OFF_RX_COUNT, 32'h0);
    rd(5'h14, 32'h0);
    acc(1'b0, `BASE_DEVICE | `OFF_RX_COUNT, 32'h0, a, q);
    chk("foreign ack", 32'h0, {31'h0, a});
  endtask
  task automatic t_transmit(input logic dt, input logic [15:0] cnt);
    txq.delete();
    lastq.delete();
    sink_on = 1'b1;
    wr(`OFF_TX_BASE, TXB);
    wr(`OFF_CONTROL, {2'b01, dt, 13'h0, cnt});
    wait_irq();
    sink_on = 1'b0;
    chk("tx count", {16'h0, cnt} + dt, 32'(txq.size()));
    for (int i = 0; i < txq.size(); i++)
    begin
      chk("tx data", (dt && i == 0) ? `DATA_FRAME_HDR : TXB + 4 * (i - dt), txq[i]);
      chk("tx last", {31'h0, i == txq.size() - 1}, lastq[i]);
    end
    wr(`OFF_INT_CLEAR, 32'h8000_0000);
    chk("irq clear", 32'h0, {31'h0, core_to_cpu_irq_o});
  endtask
  task automatic t_receive(input logic [31:0] hdr, input int n, input logic [31:0] base,
                           input logic [31:0] cnt);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk_i);
      {rx_data_i, rx_valid_i, rx_last_i} = {(i == 0) ? hdr : 32'h5500_0000 + i, 1'b1, i == n - 1};
      while (rx_ready_o !== 1'b1)
        @(negedge clk_i);
    end
    @(negedge clk_i);
    {rx_data_i, rx_valid_i, rx_last_i} = {~rx_data_i, 2'b00};
    wait_irq();
    chk("rx area", base, mem.aw_q);
    chk("rx header", hdr, mem.wbeat[0][31:0]);
    chk("rx word", 32'h5500_0001, mem.wbeat[0][63:32]);
    chk("rx pad", 32'h0, mem.wbeat[0][255:224] | mem.wbeat[15][31:0]);
    rd(`OFF_RX_COUNT, cnt);
    rd(`OFF_ERR_CODE, 32'h0000_00a5);
  endtask
  task automatic t_rx_pair;
    wr(`OFF_DATA_BASE, DB);
    wr(`OFF_OTHER_BASE, OB);
    t_receive(`DATA_FRAME_HDR, 4, DB, 32'h0000_0004);
    wr(`OFF_INT_CLEAR, 32'h8000_0000);
    t_receive(32'h0000_0034, 3, OB, 32'h8000_0003);
    wr(`OFF_INT_CLEAR, 32'ha000_0000);
    rd(`OFF_RX_COUNT, 32'h0000_0003);
    wr(`OFF_CONTROL, 32'h0);
    rd(`OFF_RX_COUNT, 32'h0);
  endtask
  task automatic t_cpu_irq;
    @(negedge clk_i);
    cpu_irq_req_i = 1'b1;
    @(negedge clk_i);
    cpu_irq_req_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk("cpu irq held", 32'h1, {31'h0, cpu_to_core_irq_o});
    wr(`OFF_INT_CLEAR, 32'h4000_0000);
    chk("cpu irq clear", 32'h0, {31'h0, cpu_to_core_irq_o});
  endtask
  task automatic t_soft_reset;
    wr(`OFF_CONTROL, 32'h6000_0028);
    repeat (3) @(negedge clk_i);
    chk("tx stalled", 32'h1, {31'h0, tx_valid_o});
    wr(`OFF_CONTROL, 32'h8000_0000);
    repeat (3) @(negedge clk_i);
    chk("tx flushed", 32'h0, {31'h0, tx_valid_o | core_to_cpu_irq_o});
  endtask
  task automatic summarize;
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #300000;
    err_total++;
    summarize();
  end
  initial
  begin
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk("irqs at reset", 32'h0, {30'h0, core_to_cpu_irq_o, cpu_to_core_irq_o});
    t_decode();
    t_transmit(1'b1, 16'd10);
    t_transmit(1'b1, 16'd0);
    t_transmit(1'b0, 16'd3);
    t_rx_pair();
    t_cpu_irq();
    t_soft_reset();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
